/* src/pcss_defs.svh */
/*
 * Constants for the coding sublayer status block: register offsets,
 * field positions, reset values and AXI4-Lite response codes.
 * Assumes it is included by bare name from files under src/.
 */
`ifndef PCSS_DEFS_SVH
`define PCSS_DEFS_SVH

// Printed address with the device group tag in the upper nibble.
`define PCSS_STATUS_TAGGED  16'h38E7
`define PCSS_GROUP_TAG      4'h3
// Register indices with the tag stripped. The printed offset is not word
// aligned, so the byte address on the bus is four times the index.
`define PCSS_STATUS_IDX     12'h8E7
// Event mask and interrupt status registers.
`define PCSS_MASK_IDX       12'h000
`define PCSS_IRQ_IDX        12'h001
`define PCSS_IDX_W          12
`define PCSS_IDX_LSB        2

`define PCSS_BIT_TX_LATCH   11
`define PCSS_BIT_RX_LATCH   10
`define PCSS_BIT_TX_LIVE    9
`define PCSS_BIT_RX_LIVE    8
`define PCSS_BIT_FAULT      7
`define PCSS_BIT_LINK       2
`define PCSS_STATUS_RESET   16'h0000
`define PCSS_WRITE_MASK     16'h0C84
`define PCSS_USED_MASK      16'h0F84
`define PCSS_RSVD_HI        15:12
`define PCSS_RSVD_MID       6:3
`define PCSS_RSVD_LO        1:0

`define PCSS_IRQ_W          4
`define PCSS_IRQ_RESET      4'h0
`define PCSS_IRQ_TX         0
`define PCSS_IRQ_RX         1
`define PCSS_IRQ_FAULT      2
`define PCSS_IRQ_LINK       3

`define PCSS_RESP_OKAY      2'h0
`define PCSS_RESP_SLVERR    2'h2

`endif

/* src/pcss_pkg.sv */
/*
 * Types for the coding sublayer status block.
 * Assumes pcss_defs.svh is on the include path.
 */
package pcss_pkg;
	typedef enum logic [1:0] {PCSS_W_IDLE, PCSS_W_RESP} pcss_wstate_t;
	typedef enum logic [1:0] {PCSS_R_IDLE, PCSS_R_RESP} pcss_rstate_t;
endpackage

/* src/pcss_sync.sv */
/*
 * Two-flop synchroniser for a bundle of level inputs.
 * Assumes the inputs are levels from outside the i_clk domain.
 */
`timescale 1ns/100ps
`default_nettype none
module pcss_sync #(
	parameter int W = 4
) (
	// Clock and reset.
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// Asynchronous in, synchronised out.
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_reg <= '0;
			o_sync   <= '0;
		end else begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end
endmodule // pcss_sync
`default_nettype wire

/* src/pcss_status.sv */
/*
 * Coding sublayer status word of a single-pair Ethernet transceiver with
 * an AXI4-Lite slave, event latching and one masked interrupt output.
 * Assumes the sublayer indications are levels from another domain; they
 * are synchronised here. Software strips the group tag before access.
 */
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pcss_defs.svh"

// Function
// [RULE_01] Bit 11 latches transmit low-power idle seen; cleared by writing zero.
// [RULE_02] Bit 10 latches receive low-power idle seen; cleared by writing zero.
// [RULE_03] Bit 9 is the live transmit low-power idle indication, not latched.
// [RULE_04] Bit 8 is the live receive low-power idle indication, not latched.
// [RULE_05] Bit 7 latches a sublayer fault; cleared by writing zero.
// [RULE_06] Bit 2 latches receive link up; a zero write returns it inactive.
// [RULE_07] Status word sits at 0x38E7 less its 0x3 group tag, resets zero.
// [RULE_08] Reserved bits 15:12, 6:3, 1:0 read zero and ignore writes.
module pcss_status
	import pcss_pkg::*;
(
	// Clock and reset.
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Sublayer indications (asynchronous levels).
	input  wire logic        i_tx_lpi,
	input  wire logic        i_rx_lpi,
	input  wire logic        i_fault,
	input  wire logic        i_link_up,
	// AXI4-Lite write address.
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	// AXI4-Lite write data.
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response.
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read address.
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	// AXI4-Lite read data.
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Interrupt.
	output logic             o_irq
);
	// Register decode; unaligned or out-of-range addresses hit nothing.
	function automatic logic [1:0] reg_hit(input logic [31:0] a);
		logic [`PCSS_IDX_W-1:0] idx;
		idx = a[`PCSS_IDX_W+`PCSS_IDX_LSB-1:`PCSS_IDX_LSB];
		if (a[31:`PCSS_IDX_W+`PCSS_IDX_LSB] != '0)
			reg_hit = 2'h0;
		else if (a[`PCSS_IDX_LSB-1:0] != '0)
			reg_hit = 2'h0;
		else if (idx == `PCSS_STATUS_IDX)
			reg_hit = 2'h1;
		else if (idx == `PCSS_MASK_IDX)
			reg_hit = 2'h2;
		else if (idx == `PCSS_IRQ_IDX)
			reg_hit = 2'h3;
		else
			reg_hit = 2'h0;
	endfunction

	logic [3:0]              sync_in;
	logic [3:0]              sync_out;
	logic                    tx_lpi_s, rx_lpi_s, fault_s, link_s;
	logic                    tx_lpi_d, rx_lpi_d, fault_d, link_d;
	logic [15:0]             status_reg;
	logic [`PCSS_IRQ_W-1:0]  mask_reg;
	logic [`PCSS_IRQ_W-1:0]  irq_reg;
	logic [`PCSS_IRQ_W-1:0]  ev;
	pcss_wstate_t            wstate_reg;
	pcss_rstate_t            rstate_reg;
	logic                    aw_have_reg, w_have_reg;
	logic [31:0]             awaddr_reg;
	logic [31:0]             wdata_reg;
	logic [3:0]              wstrb_reg;
	logic                    wr_go;
	logic [1:0]              wr_hit;
	logic                    wr_lo;

	assign sync_in = {i_link_up, i_fault, i_rx_lpi, i_tx_lpi};

	pcss_sync #(.W(4)) u_sync (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.i_async(sync_in),
		.o_sync (sync_out)
	);

	assign tx_lpi_s = sync_out[0];
	assign rx_lpi_s = sync_out[1];
	assign fault_s  = sync_out[2];
	assign link_s   = sync_out[3];

	// Edge history for the interrupt events.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tx_lpi_d <= 1'b0;
			rx_lpi_d <= 1'b0;
			fault_d  <= 1'b0;
			link_d   <= 1'b0;
		end else begin
			tx_lpi_d <= tx_lpi_s;
			rx_lpi_d <= rx_lpi_s;
			fault_d  <= fault_s;
			link_d   <= link_s;
		end
	end

	assign ev[`PCSS_IRQ_TX]    = tx_lpi_s & ~tx_lpi_d;
	assign ev[`PCSS_IRQ_RX]    = rx_lpi_s & ~rx_lpi_d;
	assign ev[`PCSS_IRQ_FAULT] = fault_s & ~fault_d;
	assign ev[`PCSS_IRQ_LINK]  = link_s & ~link_d;

	// Write channel: address and data taken in either order.
	assign wr_go  = aw_have_reg & w_have_reg & (wstate_reg == PCSS_W_IDLE);
	assign wr_hit = reg_hit(awaddr_reg);
	assign wr_lo  = wr_go & wstrb_reg[0];

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			awaddr_reg    <= 32'h0000_0000;
			wdata_reg     <= 32'h0000_0000;
			wstrb_reg     <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PCSS_RESP_OKAY;
			wstate_reg    <= PCSS_W_IDLE;
		end else begin
			case (wstate_reg)
			PCSS_W_IDLE: begin
				if (s_axi_awvalid & s_axi_awready) begin
					aw_have_reg   <= 1'b1;
					awaddr_reg    <= s_axi_awaddr;
					s_axi_awready <= 1'b0;
				end
				if (s_axi_wvalid & s_axi_wready) begin
					w_have_reg   <= 1'b1;
					wdata_reg    <= s_axi_wdata;
					wstrb_reg    <= s_axi_wstrb;
					s_axi_wready <= 1'b0;
				end
				if (wr_go) begin
					s_axi_bvalid <= 1'b1;
					s_axi_bresp  <= (wr_hit == 2'h0) ?
						`PCSS_RESP_SLVERR : `PCSS_RESP_OKAY;
					wstate_reg   <= PCSS_W_RESP;
				end
			end
			PCSS_W_RESP: begin
				if (s_axi_bready) begin
					s_axi_bvalid  <= 1'b0;
					aw_have_reg   <= 1'b0;
					w_have_reg    <= 1'b0;
					s_axi_awready <= 1'b1;
					s_axi_wready  <= 1'b1;
					wstate_reg    <= PCSS_W_IDLE;
				end
			end
			default: wstate_reg <= PCSS_W_IDLE;
			endcase
		end
	end

	// Status word. A set from hardware wins over a zero write in one cycle.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			status_reg <= `PCSS_STATUS_RESET; // RULE_07
		end else begin
			if (wr_lo && wr_hit == 2'h1) begin
				if (!wdata_reg[`PCSS_BIT_TX_LATCH])
					status_reg[`PCSS_BIT_TX_LATCH] <= 1'b0; // RULE_01
				if (!wdata_reg[`PCSS_BIT_RX_LATCH])
					status_reg[`PCSS_BIT_RX_LATCH] <= 1'b0; // RULE_02
				if (!wdata_reg[`PCSS_BIT_FAULT])
					status_reg[`PCSS_BIT_FAULT] <= 1'b0; // RULE_05
				if (!wdata_reg[`PCSS_BIT_LINK])
					status_reg[`PCSS_BIT_LINK] <= 1'b0; // RULE_06
			end
			if (tx_lpi_s)
				status_reg[`PCSS_BIT_TX_LATCH] <= 1'b1; // RULE_01
			if (rx_lpi_s)
				status_reg[`PCSS_BIT_RX_LATCH] <= 1'b1; // RULE_02
			if (fault_s)
				status_reg[`PCSS_BIT_FAULT] <= 1'b1; // RULE_05
			if (link_s)
				status_reg[`PCSS_BIT_LINK] <= 1'b1; // RULE_06
			status_reg[`PCSS_BIT_TX_LIVE] <= tx_lpi_s; // RULE_03
			status_reg[`PCSS_BIT_RX_LIVE] <= rx_lpi_s; // RULE_04
			status_reg[`PCSS_RSVD_HI]  <= 4'h0; // RULE_08
			status_reg[`PCSS_RSVD_MID] <= 4'h0; // RULE_08
			status_reg[`PCSS_RSVD_LO]  <= 2'h0; // RULE_08
		end
	end

	// Interrupt mask.
	always_ff @(posedge i_clk) begin
		if (i_rst)
			mask_reg <= `PCSS_IRQ_RESET;
		else if (wr_lo && wr_hit == 2'h2)
			mask_reg <= wdata_reg[`PCSS_IRQ_W-1:0];
	end

	// Interrupt status, write one to clear; a new event wins.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			irq_reg <= `PCSS_IRQ_RESET;
		end else if (wr_lo && wr_hit == 2'h3) begin
			irq_reg <= (irq_reg & ~wdata_reg[`PCSS_IRQ_W-1:0]) | ev;
		end else begin
			irq_reg <= irq_reg | ev;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_irq <= 1'b0;
		else
			o_irq <= |(irq_reg & mask_reg);
	end

	// Read channel: one read at a time, answer one cycle after address.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `PCSS_RESP_OKAY;
			rstate_reg    <= PCSS_R_IDLE;
		end else begin
			case (rstate_reg)
			PCSS_R_IDLE: begin
				if (s_axi_arvalid) begin
					s_axi_arready <= 1'b0;
					s_axi_rvalid  <= 1'b1;
					s_axi_rresp   <= `PCSS_RESP_OKAY;
					case (reg_hit(s_axi_araddr))
					2'h1: s_axi_rdata <= {16'h0000, status_reg}; // RULE_07
					2'h2: s_axi_rdata <= {28'h0000000, mask_reg};
					2'h3: s_axi_rdata <= {28'h0000000, irq_reg};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `PCSS_RESP_SLVERR;
					end
					endcase
					rstate_reg <= PCSS_R_RESP;
				end
			end
			PCSS_R_RESP: begin
				if (s_axi_rready) begin
					s_axi_rvalid  <= 1'b0;
					s_axi_arready <= 1'b1;
					rstate_reg    <= PCSS_R_IDLE;
				end
			end
			default: rstate_reg <= PCSS_R_IDLE;
			endcase
		end
	end

	// Checks.
	tx_latch_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_01
		tx_lpi_s |=> status_reg[`PCSS_BIT_TX_LATCH])
		else $error("tx latch not set");
	rx_latch_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_02
		rx_lpi_s |=> status_reg[`PCSS_BIT_RX_LATCH])
		else $error("rx latch not set");
	tx_live_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_03
		##1 status_reg[`PCSS_BIT_TX_LIVE] == $past(tx_lpi_s))
		else $error("tx live wrong");
	rx_live_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_04
		##1 status_reg[`PCSS_BIT_RX_LIVE] == $past(rx_lpi_s))
		else $error("rx live wrong");
	fault_hold_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_05
		(status_reg[`PCSS_BIT_FAULT] && !(wr_lo && wr_hit == 2'h1))
		|=> status_reg[`PCSS_BIT_FAULT])
		else $error("fault dropped");
	link_clear_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_06
		(wr_lo && wr_hit == 2'h1 && !wdata_reg[`PCSS_BIT_LINK] && !link_s)
		|=> !status_reg[`PCSS_BIT_LINK])
		else $error("link not cleared");
	status_read_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_07
		(rstate_reg == PCSS_R_IDLE && s_axi_arvalid
		 && reg_hit(s_axi_araddr) == 2'h1)
		|=> s_axi_rvalid && s_axi_rdata[15:0] == $past(status_reg))
		else $error("status read wrong");
	reserved_zero_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_08
		##1 (status_reg & ~`PCSS_USED_MASK) == 16'h0000)
		else $error("reserved bit set");
	tx_clear_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_01
		(wr_lo && wr_hit == 2'h1 && !tx_lpi_s
		 && !wdata_reg[`PCSS_BIT_TX_LATCH])
		|=> !status_reg[`PCSS_BIT_TX_LATCH])
		else $error("tx latch not cleared");
	tx_hold_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_01
		(status_reg[`PCSS_BIT_TX_LATCH] && !(wr_lo && wr_hit == 2'h1))
		|=> status_reg[`PCSS_BIT_TX_LATCH])
		else $error("tx latch dropped");
	rx_clear_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_02
		(wr_lo && wr_hit == 2'h1 && !rx_lpi_s
		 && !wdata_reg[`PCSS_BIT_RX_LATCH])
		|=> !status_reg[`PCSS_BIT_RX_LATCH])
		else $error("rx latch not cleared");
	rx_hold_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_02
		(status_reg[`PCSS_BIT_RX_LATCH] && !(wr_lo && wr_hit == 2'h1))
		|=> status_reg[`PCSS_BIT_RX_LATCH])
		else $error("rx latch dropped");
	fault_set_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_05
		fault_s |=> status_reg[`PCSS_BIT_FAULT])
		else $error("fault not set");
	fault_clear_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_05
		(wr_lo && wr_hit == 2'h1 && !fault_s
		 && !wdata_reg[`PCSS_BIT_FAULT])
		|=> !status_reg[`PCSS_BIT_FAULT])
		else $error("fault not cleared");
	link_set_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_06
		link_s |=> status_reg[`PCSS_BIT_LINK])
		else $error("link not set");
	link_hold_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_06
		(status_reg[`PCSS_BIT_LINK] && !(wr_lo && wr_hit == 2'h1))
		|=> status_reg[`PCSS_BIT_LINK])
		else $error("link dropped");
	write_answer_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_07
		wr_go |=> s_axi_bvalid)
		else $error("write response missing");
	read_answer_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_07
		(rstate_reg == PCSS_R_IDLE && s_axi_arvalid)
		|=> (s_axi_rvalid && !s_axi_arready))
		else $error("read response missing");
	irq_level_a: assert property (@(posedge i_clk) disable iff (i_rst)
		##1 o_irq == $past(|(irq_reg & mask_reg)))
		else $error("interrupt level wrong");
endmodule // pcss_status
`default_nettype wire

/* tb/tb.sv */
/*
 * Self-checking testbench for the coding sublayer status block.
 * Assumes pcss_defs.svh is on the include path and a 10 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pcss_defs.svh"
module tb;
	// Byte addresses are four times the register index.
	localparam logic [31:0] st_a   = {18'h0, `PCSS_STATUS_IDX, 2'h0};
	localparam logic [31:0] mask_a = {18'h0, `PCSS_MASK_IDX, 2'h0};
	localparam logic [31:0] irq_a  = {18'h0, `PCSS_IRQ_IDX, 2'h0};
	localparam logic [1:0]  okay   = `PCSS_RESP_OKAY;
	localparam logic [1:0]  err    = `PCSS_RESP_SLVERR;
	logic        i_clk;
	logic        i_rst;
	logic [3:0]  ind;
	logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr, irq;
	logic [31:0] awa, wd, ara, rd;
	logic [1:0]  bresp, rresp;
	logic [3:0]  ws;
	int          bad_count;
	int          checked;
	// Status while the source is high, then after it drops again.
	logic [15:0] hi_tab [4] = '{16'h0A00, 16'h0500, 16'h0080, 16'h0004};
	logic [15:0] lo_tab [4] = '{16'h0800, 16'h0400, 16'h0080, 16'h0004};

	pcss_status pcss_status_inst (
		.i_clk(i_clk), .i_rst(i_rst),
		.i_tx_lpi(ind[0]), .i_rx_lpi(ind[1]),
		.i_fault(ind[2]), .i_link_up(ind[3]),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.s_axi_rdata(rd), .s_axi_rresp(rresp), .o_irq(irq)
	);

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// Address and data are offered together and each released once taken.
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d,
		input logic [1:0] er);
		awa <= a;
		wd  <= d;
		awv <= 1'h1;
		wv  <= 1'h1;
		do begin
			@(posedge i_clk);
			if (awr) awv <= 1'h0;
			if (wr) wv <= 1'h0;
		end while (!bv);
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd_reg(input logic [31:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		ara <= a;
		arv <= 1'h1;
		do begin
			@(posedge i_clk);
			if (arr) arv <= 1'h0;
		end while (!rv);
		chk(rd, ed);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	initial begin
		i_clk = 1'h0;
		forever #50 i_clk = ~i_clk;
	end

	// The whole sequence needs well under a thousand cycles.
	initial begin
		#(3000 * 100);
		bad_count++;
		final_report();
	end

	initial begin
		i_rst = 1'h1;
		ind = 4'h0;
		awv = 1'h0;
		wv = 1'h0;
		arv = 1'h0;
		br = 1'h1;
		rr = 1'h1;
		ws = 4'hF;
		awa = 32'h0;
		wd = 32'h0;
		ara = 32'h0;
		bad_count = 0;
		checked = 0;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'h0;
		rd_reg(st_a, 32'h0, okay);
		rd_reg(irq_a, 32'h0, okay);
		rd_reg(mask_a, 32'h0, okay);
		rd_reg(32'h38E7, 32'h0, err);
		rd_reg(32'h8E7, 32'h0, err);
		wr_reg(32'h100, 32'hFFFF, err);
		rd_reg(32'h100, 32'h0, err);
		for (int i = 0; i < 4; i++) begin
			ind[i] <= 1'h1;
			wait_clk(5);
			rd_reg(st_a, {16'h0, hi_tab[i]}, okay);
			ind[i] <= 1'h0;
			wait_clk(5);
			rd_reg(st_a, {16'h0, lo_tab[i]}, okay);
			wr_reg(st_a, 32'hFFFF, okay);
			rd_reg(st_a, {16'h0, lo_tab[i]}, okay);
			wr_reg(st_a, 32'h0, okay);
			rd_reg(st_a, 32'h0, okay);
		end
		rd_reg(irq_a, 32'hF, okay);
		chk({31'h0, irq}, 32'h0);
		wr_reg(mask_a, 32'h4, okay);
		wait_clk(3);
		chk({31'h0, irq}, 32'h1);
		wr_reg(irq_a, 32'h4, okay);
		wait_clk(3);
		chk({31'h0, irq}, 32'h0);
		rd_reg(irq_a, 32'hB, okay);
		rd_reg(mask_a, 32'h4, okay);
		wr_reg(irq_a, 32'hB, okay);
		rd_reg(irq_a, 32'h0, okay);
		final_report();
	end
endmodule // tb
`default_nettype wire
